// ---- inc/swm_pkg.sv ----
package swm_pkg;
  localparam int CMD_W  = 24;
  localparam int PROG_N = 8;
  localparam int GND_N  = 14;
  localparam int SW_N   = PROG_N + GND_N;
  localparam int CNT_W  = 5;
  localparam int ASEL_W = 5;

  localparam logic [CNT_W-1:0] CMD_LEN = 5'h18;
  localparam int CODE_HI = 23;
  localparam int CODE_LO = 16;
  localparam int SEL_HI  = 7;
  localparam int SEL_LO  = 0;
  localparam logic [7:0] SETTINGS_CODE = 8'h01;

  localparam logic [PROG_N-1:0] PROG_TYPE_RST = 8'hFF;
  localparam logic [ASEL_W-1:0] ASEL_RST      = 5'h00;
  localparam logic              WET_ON_RST    = 1'h1;
  localparam logic              WET_TMR_RST   = 1'h1;
  localparam logic [SW_N-1:0]   TRISTATE_RST  = 22'h3FFFFF;

  typedef enum logic {
    SWM_NORMAL = 1'b0,
    SWM_SLEEP  = 1'b1
  } swm_mode_t;

  typedef struct packed {
    logic [GND_N-1:0]  gnd;
    logic [PROG_N-1:0] prog;
  } swm_sw_t;

  typedef struct packed {
    logic    int_flag;
    logic    therm;
    swm_sw_t sw;
  } swm_rsp_t;

  typedef struct packed {
    logic    wake_n;
    logic    int_n;
    logic    cs_n;
    logic    vdd_ok;
    swm_sw_t above;
  } swm_async_t;

  typedef struct packed {
    logic            wet_on;
    logic            wet_tmr_on;
    logic [SW_N-1:0] tristate;
  } swm_cfg_t;
endpackage

// ---- logic/swm_spi_wake_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module swm_spi_wake_port (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          si,
  output logic                               so_o,
  output logic                               so_oe,
  input  wire logic                          int_in,
  output logic                               int_out,
  output logic                               int_oe,
  input  wire logic                          wake_in,
  output logic                               wake_out,
  output logic                               wake_oe,
  input  wire logic                          vdd_present,
  input  wire swm_pkg::swm_sw_t              sw_above,
  input  wire logic [swm_pkg::SW_N-1:0]      irq_en,
  input  wire logic                          thermal_flag,
  input  wire logic                          sleep_req,
  output swm_pkg::swm_mode_t                 mode,
  output logic                               temp_mon_en,
  output logic [swm_pkg::PROG_N-1:0]         prog_type,
  output logic [swm_pkg::ASEL_W-1:0]         analog_select_out,
  output swm_pkg::swm_cfg_t                  cfg_out
);
  import swm_pkg::*;

  function automatic swm_async_t agree_filter(input swm_async_t s2, input swm_async_t s3,
                                              input swm_async_t held);
    agree_filter = (s2 & s3) | (held & (s2 | s3));
  endfunction

  function automatic swm_sw_t closed_of(input swm_sw_t above, input logic [PROG_N-1:0] ptype);
    swm_sw_t c;
    c.prog = ~(above.prog ^ ptype);
    c.gnd  = ~above.gnd;
    closed_of = c;
  endfunction

  // Pin synchronisers, three stages plus agree filter
  swm_async_t raw_in;
  swm_async_t sync1_reg;
  swm_async_t sync2_reg;
  swm_async_t sync3_reg;
  swm_async_t filt_reg;

  assign raw_in = '{wake_n: wake_in, int_n: int_in, cs_n: cs_n, vdd_ok: vdd_present,
                    above: sw_above};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      filt_reg  <= '1;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= agree_filter(sync2_reg, sync3_reg, filt_reg);
    end
  end

  swm_async_t prev_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= filt_reg;
    end
  end

  // Chain starts from guessed levels; edges seen before it fills are not real
  localparam int SETTLE_N = 5;
  logic [SETTLE_N-1:0] settle_reg;
  logic                settled;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= {settle_reg[SETTLE_N-2:0], 1'b1};
    end
  end
  assign settled = settle_reg[SETTLE_N-1];

  logic cs_fall;
  logic cs_rise;
  logic int_fall;
  logic wake_fall;
  assign cs_fall   = settled & prev_reg.cs_n & ~filt_reg.cs_n;
  assign cs_rise   = settled & ~prev_reg.cs_n & filt_reg.cs_n;
  assign int_fall  = settled & prev_reg.int_n & ~filt_reg.int_n;
  assign wake_fall = settled & prev_reg.wake_n & ~filt_reg.wake_n;

  // Contact state and change detection
  logic [PROG_N-1:0] ptype_reg;
  swm_sw_t           closed_now;
  swm_sw_t           closed_prev;
  logic              sw_change;
  assign closed_now  = closed_of(filt_reg.above, ptype_reg);
  assign closed_prev = closed_of(prev_reg.above, ptype_reg);
  // Type change alone is not a contact change
  assign sw_change   = settled & (|((closed_now ^ closed_prev) & irq_en));

  swm_mode_t mode_reg;
  logic      wake_evt;
  assign wake_evt = ((cs_fall | (int_fall & filt_reg.wake_n)) & filt_reg.vdd_ok)
                  | (wake_fall & (~filt_reg.vdd_ok | filt_reg.int_n))
                  | sw_change;

  // Power-on reset comes from the battery supply detector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= SWM_NORMAL;
    end else begin
      unique case (mode_reg)
        SWM_NORMAL: begin
          if (sleep_req && filt_reg.cs_n) begin
            mode_reg <= SWM_SLEEP;
          end
        end
        SWM_SLEEP: begin
          if (wake_evt) begin
            mode_reg <= SWM_NORMAL;
          end
        end
      endcase
    end
  end

  // Interrupt latch and the change-during-frame memory
  logic int_pend_reg;
  logic frame_chg_reg;
  logic int_set;
  assign int_set = sw_change && mode_reg == SWM_NORMAL;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_chg_reg <= 1'b0;
    end else if (int_set && !filt_reg.cs_n) begin
      frame_chg_reg <= 1'b1;  // A change in the select-fall cycle still counts
    end else if (cs_fall) begin
      frame_chg_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_pend_reg <= 1'b0;
    end else if (int_set) begin
      int_pend_reg <= 1'b1;  // Set wins over the release
    end else if (cs_rise) begin
      int_pend_reg <= frame_chg_reg;
    end
  end

  // Status snapshot at select fall, read by the link while select is low
  swm_rsp_t snap_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_reg <= '0;
    end else if (cs_fall) begin
      snap_reg <= '{int_flag: int_pend_reg, therm: thermal_flag, sw: closed_now};
    end
  end

  // Link domain. Held in reset while select is high, so stray clocks do nothing.
  logic              link_clr_reg;
  logic              link_rst_n;
  logic [CMD_W-1:0]  in_sr_reg;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic [CMD_W-1:0]  out_sr_reg;
  logic              loaded_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_clr_reg <= 1'b1;
    end else begin
      link_clr_reg <= prev_reg.cs_n;
    end
  end
  assign link_rst_n = rst_n & ~link_clr_reg;

  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_sr_reg   <= '0;
      bit_cnt_reg <= '0;
    end else begin
      in_sr_reg <= {in_sr_reg[CMD_W-2:0], si};
      if (bit_cnt_reg != '1) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_sr_reg <= '0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      out_sr_reg <= snap_reg;
      loaded_reg <= 1'b1;
    end else begin
      out_sr_reg <= {out_sr_reg[CMD_W-2:0], 1'b0};
    end
  end

  // Raw pin gates the driver: the synchroniser is slower than the enable window
  assign so_o  = out_sr_reg[CMD_W-1];
  assign so_oe = ~cs_n;

  // Command taken at select rise; the link is frozen then, count and word stable
  logic cmd_ok;
  assign cmd_ok = cs_rise && bit_cnt_reg == CMD_LEN && mode_reg == SWM_NORMAL;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptype_reg <= PROG_TYPE_RST;
    end else if (cmd_ok && in_sr_reg[CODE_HI:CODE_LO] == SETTINGS_CODE) begin
      ptype_reg <= in_sr_reg[SEL_HI:SEL_LO];
    end
  end

  // Settings owned by commands outside this block keep their reset values
  logic [ASEL_W-1:0] asel_reg;
  swm_cfg_t          cfg_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      asel_reg <= ASEL_RST;
      cfg_reg  <= '{wet_on: WET_ON_RST, wet_tmr_on: WET_TMR_RST, tristate: TRISTATE_RST};
    end else begin
      asel_reg <= asel_reg;
      cfg_reg  <= cfg_reg;
    end
  end

  assign int_out           = 1'b0;
  assign int_oe            = int_pend_reg;
  assign wake_out          = 1'b0;
  assign wake_oe           = mode_reg == SWM_NORMAL;
  assign mode              = mode_reg;
  assign temp_mon_en       = mode_reg == SWM_NORMAL;
  assign prog_type         = ptype_reg;
  assign analog_select_out = asel_reg;
  assign cfg_out           = cfg_reg;

  a_wake_pin_drive: assert property (@(posedge clock) disable iff (!rst_n)
    wake_oe == (mode_reg == SWM_NORMAL) && temp_mon_en == wake_oe)
    else $error("wake pin drive does not follow mode");

  a_so_tri_idle: assert property (@(posedge clock) disable iff (!rst_n)
    cs_n |-> !so_oe)
    else $error("serial output driven while deselected");

  a_link_idle: assert property (@(posedge clock) disable iff (!rst_n)
    link_clr_reg |-> bit_cnt_reg == '0 && out_sr_reg == '0 && !loaded_reg)
    else $error("link not held idle while deselected");

  a_frame_chg: assert property (@(posedge clock) disable iff (!rst_n)
    int_set && !filt_reg.cs_n |=> frame_chg_reg)
    else $error("change during frame not remembered");

  a_int_release: assert property (@(posedge clock) disable iff (!rst_n)
    cs_rise && !frame_chg_reg && !int_set |=> !int_oe)
    else $error("interrupt not released at select rise");

  a_int_kept: assert property (@(posedge clock) disable iff (!rst_n)
    cs_rise && frame_chg_reg |=> int_oe)
    else $error("interrupt lost after change during frame");

  a_int_raise: assert property (@(posedge clock) disable iff (!rst_n)
    int_set |=> int_oe)
    else $error("enabled change did not raise interrupt");

  a_cfg_apply: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_ok && in_sr_reg[CODE_HI:CODE_LO] == SETTINGS_CODE
      |=> prog_type == $past(in_sr_reg[SEL_HI:SEL_LO]))
    else $error("settings command not applied");

  a_cfg_keep: assert property (@(posedge clock) disable iff (!rst_n)
    !cmd_ok |=> $stable(prog_type))
    else $error("configuration changed without a full command");

  a_cs_wakes: assert property (@(posedge clock) disable iff (!rst_n)
    mode_reg == SWM_SLEEP && cs_fall && filt_reg.vdd_ok |=> mode_reg == SWM_NORMAL)
    else $error("select fall did not wake device");

  a_wake_gated: assert property (@(posedge clock) disable iff (!rst_n)
    mode_reg == SWM_SLEEP && !filt_reg.vdd_ok && !wake_fall && !sw_change
      |=> mode_reg == SWM_SLEEP)
    else $error("woke without logic supply");

  a_snap_take: assert property (@(posedge clock) disable iff (!rst_n)
    cs_fall |=> snap_reg.sw == $past(closed_now) && snap_reg.int_flag == $past(int_pend_reg))
    else $error("status not captured at select fall");
endmodule // swm_spi_wake_port
`default_nettype wire

// ---- verif/swm_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module swm_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0; // Idle low between frames
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Short counts only to provoke a discard
  task automatic frame(input logic [23:0] cmd, input int nbits, output logic [23:0] rsp);
    rsp = 24'h000000;
    #7 cs_n = 1'b0; // Clock low at select edge
    #200;
    for (int i = 0; i < nbits; i++) begin
      #40 si = cmd[23-i]; // MSB first
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      rsp[23-i] = so; // Taken on falling edge
    end // One pulse per bit
    #80 cs_n = 1'b1;
    si = ~si;
    #240;
  endtask
endmodule // swm_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import swm_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  wire logic         sclk, cs_n, si;
  logic              so_o, so_oe, int_out, int_oe, wake_out, wake_oe, temp_mon_en;
  logic              vdd_present, thermal_flag, sleep_req, int_pull, wake_pull;
  swm_sw_t           sw_above;
  logic [SW_N-1:0]   irq_en;
  swm_mode_t         mode;
  logic [PROG_N-1:0] prog_type;
  logic [ASEL_W-1:0] analog_select_out;
  swm_cfg_t          cfg_out;
  logic [23:0]       rsp;
  int                num_errors = 0;
  int                n_tests = 0;
  // Released serial output floats so a missing enable never matches; released int and wake lines read high
  wire logic so_line   = so_oe ? so_o : 1'bz;
  wire logic int_line  = (int_oe ? int_out : 1'b1) & ~int_pull;
  wire logic wake_line = (wake_oe ? wake_out : 1'b1) & ~wake_pull;

  always #10 clock = ~clock;

  swm_spi_wake_port i_swm_spi_wake_port (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_o(so_o), .so_oe(so_oe), .int_in(int_line), .int_out(int_out),
    .int_oe(int_oe), .wake_in(wake_line), .wake_out(wake_out), .wake_oe(wake_oe),
    .vdd_present(vdd_present), .sw_above(sw_above), .irq_en(irq_en),
    .thermal_flag(thermal_flag), .sleep_req(sleep_req), .mode(mode),
    .temp_mon_en(temp_mon_en), .prog_type(prog_type),
    .analog_select_out(analog_select_out), .cfg_out(cfg_out)
  );

  swm_host_model i_swm_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line));

  function automatic logic [23:0] rexp(logic i, logic t, swm_sw_t a, logic [7:0] ty);
    return {i, t, ~a.gnd, ~(a.prog ^ ty)};
  endfunction

  task automatic end_of_test;
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic wait_sig(input int s, input logic v);
    for (int k = 0; k < 60; k++) begin
      if ((s == 0 ? int_oe : mode) === v) return;
      tick(1);
    end
    num_errors++;
    $display("Error %s expected %b seen timeout", s == 0 ? "int_oe" : "mode", v);
    end_of_test();
  endtask

  task automatic xfer(input logic [23:0] c, input int n);
    i_swm_host_model.frame(c, n, rsp);
  endtask

  task automatic go_sleep;
    tick(1);
    sleep_req = 1'b1;
    wait_sig(1, SWM_SLEEP);
    tick(1);
    sleep_req = 1'b0;
    chk("wake_oe", wake_oe, 24'h0);
    chk("wake_line", wake_line, 24'h1);
    chk("temp_mon_en", temp_mon_en, 24'h0);
  endtask

  initial begin
    vdd_present  = 1'b1;
    sw_above     = 22'h3FFFFF;
    irq_en       = 22'h3FFFFF;
    thermal_flag = 1'b1;
    sleep_req    = 1'b0;
    int_pull     = 1'b0;
    wake_pull    = 1'b0;
    repeat (10) @(posedge clock);
    #2 rst_n = 1'b1;
    tick(10);
    chk("mode", mode, SWM_NORMAL);
    chk("wake_oe", wake_oe, 24'h1);
    chk("temp_mon_en", temp_mon_en, 24'h1);
    chk("prog_type", prog_type, PROG_TYPE_RST);
    chk("analog_select_out", analog_select_out, ASEL_RST);
    chk("cfg_out", cfg_out, {WET_ON_RST, WET_TMR_RST, TRISTATE_RST});
    chk("int_oe", int_oe, 24'h0);
    chk("so_oe", so_oe, 24'h0);
    $display("test reset done");

    sw_above = {14'h1234, 8'hA5};
    wait_sig(0, 1'b1);
    chk("int_line", int_line, 24'h0);
    xfer(24'h000000, 24);
    chk("response", rsp, rexp(1'b1, 1'b1, sw_above, 8'hFF));
    chk("so_oe", so_oe, 24'h0);
    wait_sig(0, 1'b0);
    fork
      xfer(24'h000000, 24);
      begin
        tick(100);
        sw_above.gnd[0] = ~sw_above.gnd[0];
      end
    join
    chk("int_oe", int_oe, 24'h1);
    xfer(24'h000000, 24);
    chk("response", rsp, rexp(1'b1, 1'b1, sw_above, 8'hFF));
    wait_sig(0, 1'b0);
    $display("test interrupt done");

    xfer({SETTINGS_CODE, 8'h00, 8'h0F}, 24);
    chk("prog_type", prog_type, 24'h0F);
    xfer({SETTINGS_CODE, 8'h00, 8'h33}, 23);
    chk("prog_type", prog_type, 24'h0F);
    tick(1);
    thermal_flag = 1'b0;
    xfer(24'h000000, 24);
    chk("response", rsp, rexp(1'b0, 1'b0, sw_above, 8'h0F));
    chk("int_oe", int_oe, 24'h0);
    tick(1);
    irq_en[0] = 1'b0;
    sw_above.prog[0] = ~sw_above.prog[0];
    tick(20);
    chk("int_oe", int_oe, 24'h0);
    irq_en[0] = 1'b1;
    $display("test settings done");

    go_sleep();
    tick(1);
    vdd_present = 1'b0;
    xfer(24'h000000, 24);
    tick(1);
    int_pull = 1'b1;
    tick(20);
    chk("mode", mode, SWM_SLEEP);
    int_pull  = 1'b0;
    wake_pull = 1'b1;
    wait_sig(1, SWM_NORMAL);
    tick(1);
    wake_pull   = 1'b0;
    vdd_present = 1'b1;
    chk("wake_oe", wake_oe, 24'h1);
    go_sleep();
    int_pull = 1'b1;
    wait_sig(1, SWM_NORMAL);
    tick(1);
    int_pull = 1'b0;
    go_sleep();
    xfer(24'h000000, 24);
    chk("mode", mode, SWM_NORMAL);
    $display("test sleep done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
